// >>> cwgr_params.svh
// Offsets, field positions, reset values and codes of the waveform control registers
// What this block does
// - Per-output polarity bit inverts outputs A to D
// - Control bit 5 reads live data input
// - Clock select: system clock or fast oscillator
// - Four-bit field selects the waveform source
// - Steer enable drives polarity-adjusted data waveform
// - Steer disabled drives the override data bit
// - Steering bits act only in modes 00x
// - Steer enables double-buffered in synchronous steering
// - Shutdown bit shows shutdown, hardware and software set
// - Software may force shutdown while disabled
// - Hold shutdown until next data rising edge
// - Two-bit level field for outputs B, D
// - Two-bit level field for outputs A, C
// - Five enables gate the shutdown sources
// - Rising dead band delays N system clocks, or N-1 to N fast oscillator periods
// - Zero dead-band count bypasses the delay
// - Unimplemented bits read zero, ignore writes
// - Active-low sources force override levels three clocks after the synchroniser
// - Active source keeps shutdown; software cannot clear
// - Auto-restart clears shutdown when sources gone
// - Every shutdown event raises the interrupt flag
`ifndef CWGR_PARAMS_SVH
`define CWGR_PARAMS_SVH
`define CWGR_OFF_POL 8'h00
`define CWGR_OFF_CLK 8'h04
`define CWGR_OFF_SRC 8'h08
`define CWGR_OFF_STEER 8'h0C
`define CWGR_OFF_SDC 8'h10
`define CWGR_OFF_SDE 8'h14
`define CWGR_OFF_DBR 8'h18
`define CWGR_OFF_CTRL 8'h1C
`define CWGR_IN_BIT 5
`define CWGR_SD_BIT 7
`define CWGR_REN_BIT 6
`define CWGR_EN_BIT 7
`define CWGR_NUM_SRC 4'hE
`define CWGR_LVL_RESET 2'h1
`define CWGR_LVL_HIGH 2'h3
`define CWGR_LVL_LOW 2'h2
`define CWGR_LVL_TRI 2'h1
`define CWGR_LVL_INACT 2'h0
`endif

// >>> cwgr_pkg.sv
// Types of the waveform control block
package cwgr_pkg;
  typedef enum logic [2:0] {
    CWGR_MODE_ASYNC = 3'h0,
    CWGR_MODE_SYNC = 3'h1,
    CWGR_MODE_FWD = 3'h2,
    CWGR_MODE_REV = 3'h3,
    CWGR_MODE_HALF = 3'h4,
    CWGR_MODE_PP = 3'h5
  } cwgr_mode_t;

  // Bit i of the packed value is the source of select code i
  typedef struct packed {
    logic [3:0] logic_cell;
    logic numeric_oscillator_1;
    logic [1:0] modulator;
    logic [3:0] capture_compare_unit;
    logic comparator2_result;
    logic comparator1_result;
    logic remapped_pin_input;
  } cwgr_src_t;

  typedef struct packed {
    logic [3:0] val;
    logic [3:0] oe;
  } cwgr_wave_t;

  typedef struct packed {
    logic en;
    logic [2:0] mode;
    logic [3:0] pol;
    logic cs;
    logic [3:0] dsel;
    logic [3:0] ovr;
    logic [3:0] steer;
    logic [3:0] steer_eff;
    logic shutdown;
    logic ren;
    logic [1:0] lvl_bd;
    logic [1:0] lvl_ac;
    logic [4:0] sde;
    logic [5:0] rising_deadband;
    logic [13:0] s1;
    logic [13:0] s2;
    logic osc1;
    logic osc2;
    logic osc3;
    logic data_prev;
    logic hold;
    logic [5:0] db_cnt;
    logic db_busy;
    logic db_wave;
    cwgr_wave_t wave;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } cwgr_state_t;
endpackage

// >>> cwgr_regs.sv
// Register-controlled waveform steering, polarity, dead band and auto-shutdown
`timescale 1ns/1ps
`include "cwgr_params.svh"
module cwgr_regs (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Waveform sources and fast oscillator
  input wire cwgr_pkg::cwgr_src_t src_in,
  input wire logic fast_internal_osc,
  // Outputs to the power stage
  output cwgr_pkg::cwgr_wave_t wave_out,
  output logic shutdown_irq_flag
);

  cwgr_pkg::cwgr_state_t s;
  cwgr_pkg::cwgr_state_t s_next;
  logic data_in;
  logic data_rise;
  logic tick;
  logic sd_hw;
  logic acc;
  logic wr;
  logic wr_sd;
  logic [3:0] steer_use;
  logic [4:0] sd_src;

  ////////////////////////////////////////////////////////////////////////////
  // Level forced by a shutdown code: {oe, value}
  function automatic logic [1:0] lvl_out(input logic [1:0] code, input logic pol);
    case (code)
      `CWGR_LVL_HIGH: lvl_out = 2'h3;
      `CWGR_LVL_LOW: lvl_out = 2'h2;
      `CWGR_LVL_TRI: lvl_out = 2'h0;
      default: lvl_out = {1'b1, pol};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decoded conditions
  assign data_in = (s.dsel < `CWGR_NUM_SRC) ? s.s2[s.dsel] : 1'b0;
  assign data_rise = data_in & ~s.data_prev;
  assign tick = s.cs ? (s.osc2 & ~s.osc3) : 1'b1;
  assign sd_src = {s.s2[13], s.s2[11], s.s2[2], s.s2[1], s.s2[0]};
  assign sd_hw = |(s.sde & ~sd_src);
  assign acc = psel & penable & s.pready;
  assign wr = acc & pwrite;
  assign wr_sd = wr && (paddr == `CWGR_OFF_SDC);
  assign steer_use = (s.mode == cwgr_pkg::CWGR_MODE_SYNC) ? s.steer_eff : s.steer;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [1:0] lv;
    lv = 2'h0;
    s_next = s;
    // Synchronisers
    s_next.s1 = src_in;
    s_next.s2 = s.s1;
    s_next.osc1 = fast_internal_osc;
    s_next.osc2 = s.osc1;
    s_next.osc3 = s.osc2;
    s_next.data_prev = data_in;
    // APB: one wait state, then answer
    s_next.pready = psel & penable & ~s.pready;
    s_next.pslverr = 1'b0;
    if (psel & penable & ~s.pready) begin
      s_next.prdata = 32'h0;
      case (paddr)
        `CWGR_OFF_POL: s_next.prdata = {26'h0, data_in, 1'b0, s.pol};
        `CWGR_OFF_CLK: s_next.prdata = {31'h0, s.cs};
        `CWGR_OFF_SRC: s_next.prdata = {28'h0, s.dsel};
        `CWGR_OFF_STEER: s_next.prdata = {24'h0, s.ovr, s.steer};
        `CWGR_OFF_SDC: s_next.prdata = {24'h0, s.shutdown, s.ren, s.lvl_bd, s.lvl_ac, 2'h0};
        `CWGR_OFF_SDE: s_next.prdata = {27'h0, s.sde};
        `CWGR_OFF_DBR: s_next.prdata = {26'h0, s.rising_deadband};
        `CWGR_OFF_CTRL: s_next.prdata = {24'h0, s.en, 4'h0, s.mode};
        default: s_next.pslverr = 1'b1;
      endcase
    end
    // Register writes; unimplemented bits dropped
    if (wr) begin
      case (paddr)
        `CWGR_OFF_POL: s_next.pol = pwdata[3:0];
        `CWGR_OFF_CLK: s_next.cs = pwdata[0];
        `CWGR_OFF_SRC: s_next.dsel = pwdata[3:0];
        `CWGR_OFF_STEER: begin
          s_next.ovr = pwdata[7:4];
          s_next.steer = pwdata[3:0];
        end
        `CWGR_OFF_SDC: begin
          s_next.ren = pwdata[`CWGR_REN_BIT];
          s_next.lvl_bd = pwdata[5:4];
          s_next.lvl_ac = pwdata[3:2];
        end
        `CWGR_OFF_SDE: s_next.sde = pwdata[4:0];
        `CWGR_OFF_DBR: s_next.rising_deadband = pwdata[5:0];
        `CWGR_OFF_CTRL: begin
          s_next.en = pwdata[`CWGR_EN_BIT];
          s_next.mode = pwdata[2:0];
        end
        default: ;
      endcase
    end
    // Shutdown status: auto clear, then software, then hardware set wins
    if (s.shutdown && s.ren && !sd_hw) begin
      s_next.shutdown = 1'b0;
    end
    if (wr_sd) begin
      s_next.shutdown = pwdata[`CWGR_SD_BIT];
    end
    if (sd_hw) begin
      s_next.shutdown = 1'b1;
    end
    s_next.irq = s_next.shutdown & ~s.shutdown;
    // Outputs stay forced until a data rising edge after the clear
    if (s.shutdown) begin
      s_next.hold = 1'b1;
    end else if (data_rise) begin
      s_next.hold = 1'b0;
    end
    // Synchronous steering loads on the data rising edge
    if (s.mode != cwgr_pkg::CWGR_MODE_SYNC || data_rise) begin
      s_next.steer_eff = s.steer;
    end
    // Rising dead band
    if (!data_in) begin
      s_next.db_wave = 1'b0;
      s_next.db_busy = 1'b0;
    end else if (data_rise) begin
      if (s.rising_deadband == 6'h0) begin
        s_next.db_wave = 1'b1;
      end else begin
        s_next.db_busy = 1'b1;
        s_next.db_cnt = s.rising_deadband;
      end
    end else if (s.db_busy && tick) begin
      if (s.db_cnt == 6'h1) begin
        s_next.db_busy = 1'b0;
        s_next.db_wave = 1'b1;
      end else begin
        s_next.db_cnt = s.db_cnt - 6'h1;
      end
    end
    // Output drive
    for (int i = 0; i < 4; i++) begin
      if (s.hold) begin
        lv = lvl_out(i[0] ? s.lvl_bd : s.lvl_ac, s.pol[i]);
        s_next.wave.oe[i] = lv[1];
        s_next.wave.val[i] = lv[0];
      end else if (!s.en) begin
        s_next.wave.oe[i] = 1'b1;
        s_next.wave.val[i] = s.pol[i];
      end else if (s.mode[2:1] == 2'h0) begin
        s_next.wave.oe[i] = 1'b1;
        s_next.wave.val[i] = steer_use[i] ? (s.db_wave ^ s.pol[i]) : s.ovr[i];
      end else begin
        s_next.wave.oe[i] = 1'b1;
        s_next.wave.val[i] = s.db_wave ^ s.pol[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.lvl_bd <= `CWGR_LVL_RESET;
      s.lvl_ac <= `CWGR_LVL_RESET;
      s.hold <= 1'b1;
    end else begin
      s <= s_next;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign wave_out = s.wave;
  assign shutdown_irq_flag = s.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence rise_held_s;
    data_rise && s.rising_deadband == 6'h5 && !s.cs ##1 data_in [*5];
  endsequence

  sequence apb_setup_s;
    psel && penable && !s.pready;
  endsequence

  sequence sd_event_s;
    !s.shutdown ##1 s.shutdown;
  endsequence

  sequence sw_clear_s;
    wr_sd && !pwdata[`CWGR_SD_BIT] && !sd_hw;
  endsequence

  sequence restart_s;
    s.hold && !s.shutdown && data_rise;
  endsequence

  sequence zero_rise_s;
    data_rise && s.rising_deadband == 6'h0;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // Shutdown status and interrupt
  hw_shutdown_set_a: assert property (sd_hw |=> s.shutdown)
    else $error("active source did not set shutdown");

  shutdown_irq_a: assert property ($rose(s.shutdown) |-> s.irq && shutdown_irq_flag)
    else $error("shutdown event without flag");

  auto_restart_a: assert property (s.shutdown && s.ren && !sd_hw && !wr_sd |=> !s.shutdown)
    else $error("auto restart did not clear shutdown");

  resume_edge_a: assert property ($fell(s.shutdown) |-> s.hold)
    else $error("outputs released before data edge");

  event_irq_a: assert property (sd_event_s |-> s.irq)
    else $error("shutdown rise without interrupt pulse");

  irq_only_event_a: assert property (s.irq |-> s.shutdown && !$past(s.shutdown))
    else $error("interrupt pulse without shutdown event");

  sw_set_a: assert property (wr_sd && pwdata[`CWGR_SD_BIT] |=> s.shutdown)
    else $error("software did not set shutdown");

  sw_clear_a: assert property (sw_clear_s |=> !s.shutdown)
    else $error("software did not clear shutdown");

  active_keep_a: assert property (s.shutdown && sd_hw |=> s.shutdown)
    else $error("shutdown cleared while source active");

  manual_keep_a: assert property (s.shutdown && !s.ren && !wr_sd |=> s.shutdown)
    else $error("shutdown cleared without software");

  source_cmp2_a: assert property (s.sde[2] && !s.s2[2] |=> s.shutdown)
    else $error("enabled comparator source ignored");

  force_soon_a: assert property (sd_hw |=> ##1 s.hold)
    else $error("outputs not forced after source");

  ////////////////////////////////////////////////////////////////////////////
  // Hold and release of the forced levels
  hold_while_sd_a: assert property (s.shutdown |=> s.hold)
    else $error("hold dropped during shutdown");

  hold_keep_a: assert property (s.hold && !s.shutdown && !data_rise |=> s.hold)
    else $error("hold released without data edge");

  release_edge_a: assert property (restart_s |=> !s.hold)
    else $error("hold kept after data edge");

  tri_level_a: assert property (s.hold && s.lvl_ac == `CWGR_LVL_TRI |=> !wave_out.oe[0])
    else $error("tri-state code still drives output a");

  tri_bd_a: assert property (s.hold && s.lvl_bd == `CWGR_LVL_TRI |=> !wave_out.oe[1])
    else $error("tri-state code still drives output b");

  high_ac_a: assert property (s.hold && s.lvl_ac == `CWGR_LVL_HIGH
    |=> wave_out.oe[0] && wave_out.val[0])
    else $error("high level not on output a");

  low_bd_a: assert property (s.hold && s.lvl_bd == `CWGR_LVL_LOW
    |=> wave_out.oe[1] && !wave_out.val[1])
    else $error("low level not on output b");

  inact_bd_a: assert property (s.hold && s.lvl_bd == `CWGR_LVL_INACT
    |=> wave_out.oe[1] && wave_out.val[1] == $past(s.pol[1]))
    else $error("inactive level not on output b");

  ////////////////////////////////////////////////////////////////////////////
  // Steering, polarity and dead band
  override_drive_a: assert property (!s.hold && s.en && s.mode == 3'h0 && !s.steer[0]
    |=> wave_out.val[0] == $past(s.ovr[0]))
    else $error("override bit not on output a");

  steer_wave_a: assert property (!s.hold && s.en && s.mode == 3'h0 && s.steer[1]
    |=> wave_out.val[1] == $past(s.db_wave ^ s.pol[1]))
    else $error("steered wave not on output b");

  sync_ovr_a: assert property (!s.hold && s.en && s.mode == 3'h1 && !s.steer_eff[1]
    |=> wave_out.val[1] == $past(s.ovr[1]))
    else $error("buffered override not on output b");

  disabled_idle_a: assert property (!s.hold && !s.en
    |=> wave_out.oe == 4'hF && wave_out.val == $past(s.pol))
    else $error("disabled outputs not at idle level");

  dead_bypass_a: assert property (data_rise && s.rising_deadband == 6'h0 |=> s.db_wave)
    else $error("zero dead band delayed edge");

  zero_busy_a: assert property (zero_rise_s |=> !s.db_busy)
    else $error("zero dead band started a count");

  dead_delay_a: assert property (rise_held_s |-> !s.db_wave ##1 s.db_wave)
    else $error("dead band delay wrong");

  dead_early_a: assert property (data_rise && s.rising_deadband != 6'h0 |=> !s.db_wave)
    else $error("dead band edge passed early");

  dead_idle_a: assert property (!data_in |=> !s.db_wave)
    else $error("dead band wave high with data low");

  dead_tick_a: assert property (s.db_busy && data_in && !tick
    |=> s.db_busy && $stable(s.db_cnt))
    else $error("dead band counted without a tick");

  sync_steer_a: assert property (s.mode == 3'h1 && !data_rise |=> $stable(s.steer_eff))
    else $error("buffered steering changed off edge");

  sync_load_a: assert property (s.mode == 3'h1 && data_rise
    |=> s.steer_eff == $past(s.steer))
    else $error("buffered steering not loaded on edge");

  async_steer_a: assert property (s.mode == 3'h0 |=> s.steer_eff == $past(s.steer))
    else $error("direct steering not applied");

  polarity_a: assert property (!s.hold && s.en && s.mode[2:1] != 2'h0
    |=> wave_out.val == $past({4{s.db_wave}} ^ s.pol))
    else $error("polarity not applied");

  reserved_src_a: assert property (s.dsel >= `CWGR_NUM_SRC |-> !data_in)
    else $error("reserved source gave data");

  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  apb_wait_a: assert property (apb_setup_s |=> pready)
    else $error("no answer after one wait state");

  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");

  unmapped_err_a: assert property (apb_setup_s ##0 (paddr > `CWGR_OFF_CTRL || paddr[1:0] != 2'h0)
    |=> pslverr && prdata == 32'h0)
    else $error("unmapped address not refused");

  input_read_a: assert property (psel && penable && !s.pready && !pwrite
    && paddr == `CWGR_OFF_POL |=> prdata[5] == $past(data_in))
    else $error("input level read back wrong");

  pol_read_a: assert property (apb_setup_s ##0 (paddr == `CWGR_OFF_POL)
    |=> prdata[31:6] == 26'h0 && !prdata[4])
    else $error("unused polarity bits read nonzero");

  clk_read_a: assert property (apb_setup_s ##0 (paddr == `CWGR_OFF_CLK)
    |=> prdata == {31'h0, $past(s.cs)})
    else $error("clock select read back wrong");

  src_read_a: assert property (apb_setup_s ##0 (paddr == `CWGR_OFF_SRC)
    |=> prdata == {28'h0, $past(s.dsel)})
    else $error("source select read back wrong");

  sdc_read_a: assert property (apb_setup_s ##0 (paddr == `CWGR_OFF_SDC)
    |=> prdata[31:8] == 24'h0 && prdata[1:0] == 2'h0)
    else $error("unused shutdown bits read nonzero");

  sde_read_a: assert property (apb_setup_s ##0 (paddr == `CWGR_OFF_SDE)
    |=> prdata[31:5] == 27'h0)
    else $error("unused enable bits read nonzero");

  dbr_read_a: assert property (apb_setup_s ##0 (paddr == `CWGR_OFF_DBR)
    |=> prdata[31:6] == 26'h0)
    else $error("unused dead band bits read nonzero");

  pol_write_a: assert property (wr && paddr == `CWGR_OFF_POL
    |=> s.pol == $past(pwdata[3:0]))
    else $error("polarity write lost");

  clk_write_a: assert property (wr && paddr == `CWGR_OFF_CLK |=> s.cs == $past(pwdata[0]))
    else $error("clock select write lost");

  src_write_a: assert property (wr && paddr == `CWGR_OFF_SRC
    |=> s.dsel == $past(pwdata[3:0]))
    else $error("source select write lost");

  steer_write_a: assert property (wr && paddr == `CWGR_OFF_STEER
    |=> {s.ovr, s.steer} == $past(pwdata[7:0]))
    else $error("steering write lost");

  level_write_a: assert property (wr_sd
    |=> {s.ren, s.lvl_bd, s.lvl_ac} == $past(pwdata[6:2]))
    else $error("shutdown control write lost");

  sde_write_a: assert property (wr && paddr == `CWGR_OFF_SDE
    |=> s.sde == $past(pwdata[4:0]))
    else $error("source enable write lost");

  dbr_write_a: assert property (wr && paddr == `CWGR_OFF_DBR
    |=> s.rising_deadband == $past(pwdata[5:0]))
    else $error("dead band write lost");

endmodule // cwgr_regs

// >>> cwgr_src_model.sv
// Model of the waveform sources and the fast oscillator
`timescale 1ns/1ps
module cwgr_src_model (
  // Clock
  input wire logic pclk,
  // Levels asked for by the bench
  input wire logic [13:0] lvl,
  // Sources seen by the block
  output cwgr_pkg::cwgr_src_t src_in,
  output logic fast_internal_osc
);
  logic [1:0] div = 2'h0;
  initial src_in = 14'h3FFF;
  initial fast_internal_osc = 1'b0;
  always @(posedge pclk) begin
    src_in <= cwgr_pkg::cwgr_src_t'(lvl);
    div <= div + 2'h1;
    if (div == 2'h2) fast_internal_osc <= ~fast_internal_osc;
  end
endmodule // cwgr_src_model

// >>> testbench.sv
// Self-checking bench of the waveform control registers
`timescale 1ns/1ps
`include "cwgr_params.svh"
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, osc, se;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, w;
  logic [13:0] lvl;
  logic [15:0] seed;
  cwgr_pkg::cwgr_src_t src;
  cwgr_pkg::cwgr_wave_t wave;
  int err_count, cmp_count, irq_n, l0, l5, l1;
  logic [31:0] msk [8] = '{32'h0F, 32'h01, 32'h0F, 32'hFF, 32'h7C, 32'h1F, 32'h3F, 32'h87};
  cwgr_regs cwgr_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_in(src), .fast_internal_osc(osc), .wave_out(wave),
    .shutdown_irq_flag(irq));
  cwgr_src_model cwgr_src_model_inst (.pclk(pclk), .lvl(lvl), .src_in(src),
    .fast_internal_osc(osc));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) if (irq === 1'b1) irq_n++;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20) chk(32'h0, 32'h1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic dat(input logic v);
    lvl[7] <= v;
    cyc(8);
  endtask
  task automatic lat(output int l);
    dat(1'b0);
    cyc(4);
    lvl[7] <= 1'b1;
    l = 0;
    while (wave.val[1] !== 1'b1 && l < 200) begin
      @(posedge pclk);
      l++;
    end
  endtask
  task automatic summarize;
    $display("checks=%0d errors=%0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #400000;
    err_count++;
    summarize();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lvl = 14'h3FFF;
    seed = 16'h003C;
    cyc(10);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) rchk(8'(i * 4), msk[i], (i == 4) ? 32'h14 : 32'h0);
    xfer(1'b1, 8'h20, 32'hFF);
    xfer(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    chk(32'(se), 32'h1);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      w = {16'h0, seed} & ((i == 4) ? ~32'h80 : 32'hFF);
      xfer(1'b1, 8'(i * 4), w);
      rchk(8'(i * 4), (i == 0) ? 32'hDF : 32'hFF, w & msk[i]);
    end
    xfer(1'b1, `CWGR_OFF_SDE, 32'h0);
    xfer(1'b1, `CWGR_OFF_SDC, 32'h0);
    xfer(1'b1, `CWGR_OFF_DBR, 32'h0);
    xfer(1'b1, `CWGR_OFF_CLK, 32'h0);
    for (int c = 0; c < 16; c++) begin
      xfer(1'b1, `CWGR_OFF_SRC, 32'(c));
      lvl <= (c < 14) ? 14'(1 << c) : 14'h3FFF;
      cyc(6);
      rchk(`CWGR_OFF_POL, 32'h20, (c < 14) ? 32'h20 : 32'h0);
    end
    lvl <= 14'h3FFF;
    xfer(1'b1, `CWGR_OFF_SRC, 32'h7);
    xfer(1'b1, `CWGR_OFF_POL, 32'h5);
    xfer(1'b1, `CWGR_OFF_STEER, 32'h43);
    xfer(1'b1, `CWGR_OFF_CTRL, 32'h80);
    dat(1'b0);
    dat(1'b1);
    chk(32'(wave), 32'h6F);
    dat(1'b0);
    chk(32'(wave), 32'h5F);
    lat(l0);
    xfer(1'b1, `CWGR_OFF_DBR, 32'h5);
    lat(l5);
    chk(32'((l5 - l0) inside {[5:6]}), 32'h1);
    xfer(1'b1, `CWGR_OFF_CLK, 32'h1);
    lat(l1);
    chk(32'(l1 > l5 + 20), 32'h1);
    xfer(1'b1, `CWGR_OFF_CLK, 32'h0);
    xfer(1'b1, `CWGR_OFF_DBR, 32'h0);
    xfer(1'b1, `CWGR_OFF_CTRL, 32'h81);
    xfer(1'b1, `CWGR_OFF_STEER, 32'h52);
    cyc(8);
    chk(32'(wave), 32'h6F);
    dat(1'b0);
    dat(1'b1);
    chk(32'(wave), 32'h7F);
    xfer(1'b1, `CWGR_OFF_CTRL, 32'h82);
    cyc(8);
    chk(32'(wave), 32'hAF);
    xfer(1'b1, `CWGR_OFF_CTRL, 32'h80);
    xfer(1'b1, `CWGR_OFF_STEER, 32'h43);
    xfer(1'b1, `CWGR_OFF_SDE, 32'h04);
    xfer(1'b1, `CWGR_OFF_SDC, 32'h38);
    lvl[1] <= 1'b0;
    cyc(8);
    chk(32'(wave), 32'h6F);
    lvl[1] <= 1'b1;
    lvl[2] <= 1'b0;
    cyc(8);
    chk(32'(wave), 32'hAF);
    xfer(1'b1, `CWGR_OFF_SDC, 32'h38);
    rchk(`CWGR_OFF_SDC, 32'h80, 32'h80);
    lvl[2] <= 1'b1;
    cyc(6);
    rchk(`CWGR_OFF_SDC, 32'h80, 32'h80);
    xfer(1'b1, `CWGR_OFF_SDC, 32'h38);
    rchk(`CWGR_OFF_SDC, 32'h80, 32'h0);
    chk(32'(wave), 32'hAF);
    dat(1'b0);
    dat(1'b1);
    chk(32'(wave), 32'h6F);
    xfer(1'b1, `CWGR_OFF_CTRL, 32'h0);
    xfer(1'b1, `CWGR_OFF_SDC, 32'h94);
    cyc(4);
    chk(32'(wave.oe), 32'h0);
    xfer(1'b1, `CWGR_OFF_SDC, 32'h78);
    xfer(1'b1, `CWGR_OFF_CTRL, 32'h80);
    lvl[2] <= 1'b0;
    cyc(8);
    lvl[2] <= 1'b1;
    cyc(8);
    rchk(`CWGR_OFF_SDC, 32'h80, 32'h0);
    chk(32'(irq_n), 32'h3);
    summarize();
  end
endmodule // testbench
